// File: core/motion_cmd_pkg.sv
/*
  Constants, opcodes, register offsets and state codes of the command core.
  Assumes a Wishbone master that writes ARG before CMD.
*/
// Contract
// [RQ1] Motion query returns per-axis moving bitmap
// [RQ2] Ready query returns B1h ready, B0h busy
// [RQ3] Wave query returns running generator bitmap
// [RQ4] Short stop halts all, error 10, silent
// [RQ5] Stop ends motion from every source
// [RQ6] Closed-loop position axis stops at present position
// [RQ7] Closed-loop velocity/force axis target becomes zero
// [RQ8] Open-loop axis stops at autozero result
// [RQ9] Stop disconnects analog input; host reconnects
// [RQ10] Identity query returns name, serial, firmware, LF
// [RQ11] Offset set at level 0; generic needs 1
// [RQ12] Offset acts only with input channel connected
// [RQ13] Target or control equals analog plus offset
// [RQ14] Out-of-range result clamps silently to limit
// [RQ15] Target set on analog axis gives error 72
// [RQ16] Stops abort autozero; result and motion reported
// [RQ17] Autozero finds control value for zero force
// [RQ18] NaN low position uses stored low parameter
// [RQ19] Host references axis before starting autozero
// [RQ20] Autozero pauses analog source, then restores it
// [RQ21] Autozero travels low to high, ends low; core drives high position first, then low
// [RQ22] Low position clamps to position range
// [RQ23] Autozero query returns 1 success, 0 failure
// [RQ24] Unknown axis gives error, state unchanged
// [RQ25] Status queries answer at once, always
package motion_cmd_pkg;
  // ------------------------------------------------
  // Register offsets
  // ------------------------------------------------
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_ARG    = 8'h04;
  localparam logic [7:0] OFS_RESP   = 8'h08;
  localparam logic [7:0] OFS_ERR    = 8'h0C;
  localparam logic [7:0] OFS_LEVEL  = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // ------------------------------------------------
  // Command opcodes, CMD bits 3:0
  // ------------------------------------------------
  localparam logic [3:0] OP_MOTION    = 4'h1;
  localparam logic [3:0] OP_READY     = 4'h2;
  localparam logic [3:0] OP_WAVE      = 4'h3;
  localparam logic [3:0] OP_STOP_CHAR = 4'h4;
  localparam logic [3:0] OP_STOP_ALL  = 4'h5;
  localparam logic [3:0] OP_IDENT     = 4'h6;
  localparam logic [3:0] OP_OFS_SET   = 4'h7;
  localparam logic [3:0] OP_OFS_QRY   = 4'h8;
  localparam logic [3:0] OP_AZ_START  = 4'h9;
  localparam logic [3:0] OP_AZ_QRY    = 4'hA;
  localparam logic [3:0] OP_PARAM_OFS = 4'hB;
  localparam logic [3:0] OP_LEVEL     = 4'hC;
  localparam logic [3:0] OP_TARGET    = 4'hD;
  localparam logic [3:0] OP_LINK      = 4'hE;
  // ------------------------------------------------
  // Codes and reset values
  // ------------------------------------------------
  localparam logic [7:0] ERR_NONE     = 8'h00;
  localparam logic [7:0] ERR_STOPPED  = 8'h0A;
  localparam logic [7:0] ERR_ANALOG   = 8'h48;
  localparam logic [7:0] ERR_BAD_AXIS = 8'h0F;
  localparam logic [7:0] ERR_LEVEL    = 8'h3C;
  localparam logic [7:0] READY_YES    = 8'hB1;
  localparam logic [7:0] READY_NO     = 8'hB0;
  localparam logic [7:0] ID_LF        = 8'h0A;
  // Identity fields, values arbitrary
  localparam logic [7:0] ID_NAME      = 8'h4D;
  localparam logic [7:0] ID_SERIAL    = 8'h5A;
  localparam logic [7:0] ID_FW        = 8'h10;
  localparam logic [31:0] AZ_SETTLE   = 32'h0000_0010;
  typedef enum logic [2:0] {
    AZ_IDLE = 3'b001,
    AZ_HIGH = 3'b010,
    AZ_LOW  = 3'b100
  } az_state_e;
endpackage

// File: core/motion_cmd_core.sv
/*
  Command core: status queries, stop, analog offset, autozero.
  Assumes servo, profile and wave logic on core_clk feed the axis inputs.
*/
module motion_cmd_core #(
  parameter int          NAX    = 2,
  parameter int          NWG    = 2,
  parameter int          W      = 16,
  parameter int unsigned AZ_TMO = 32'h0100_0000
) (
  input  wire logic                  core_clk,
  input  wire logic                  resetn,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [31:0]           wb_dat_i,
  input  wire logic [3:0]            wb_sel_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic [NAX-1:0]        servo_on,
  input  wire logic [NAX-1:0]        pos_ctrl,
  input  wire logic [NAX-1:0]        move_busy,
  input  wire logic [NAX-1:0]        ref_busy,
  input  wire logic [NAX-1:0]        in_position,
  input  wire logic [NWG-1:0]        wave_run,
  input  wire logic [NAX-1:0][W-1:0] position,
  input  wire logic [NAX-1:0][W-1:0] analog_val,
  input  wire logic [NAX-1:0][W-1:0] force_val,
  input  wire logic [NAX-1:0][W-1:0] servo_out,
  input  wire logic [NAX-1:0][W-1:0] cl_min,
  input  wire logic [NAX-1:0][W-1:0] cl_max,
  input  wire logic [NAX-1:0][W-1:0] ol_min,
  input  wire logic [NAX-1:0][W-1:0] ol_max,
  input  wire logic [NAX-1:0][W-1:0] pos_min,
  input  wire logic [NAX-1:0][W-1:0] pos_max,
  input  wire logic [NAX-1:0][W-1:0] az_low_par,
  input  wire logic [NAX-1:0][W-1:0] az_high_par,
  output logic      [NAX-1:0][W-1:0] target_value,
  output logic      [NAX-1:0][W-1:0] control_value,
  output logic      [NAX-1:0][W-1:0] az_result,
  output logic      [NAX-1:0][W-1:0] analog_offset,
  output logic      [NAX-1:0]        analog_link,
  output logic                       stop_pulse
);
  // ------------------------------------------------
  // Reset release
  // ------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n_q);
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ------------------------------------------------
  // Bus decode
  // ------------------------------------------------
  logic                 ack_q;
  logic [31:0]          dat_q;
  logic signed [W-1:0]  arg_q;
  logic                 arg_nan_q;
  logic                 level_q;
  logic [7:0]           err_q;
  logic [7:0]           err_d;
  logic [31:0]          resp_q;
  logic [31:0]          resp_d;
  logic                 stop_q;
  logic signed [W-1:0]  tgt_q [NAX];
  logic signed [W-1:0]  ctl_q [NAX];
  logic signed [W-1:0]  ofs_q [NAX];
  logic signed [W-1:0]  azr_q [NAX];
  logic signed [W-1:0]  low_q [NAX];
  logic [31:0]          tmr_q [NAX];
  motion_cmd_pkg::az_state_e az_q [NAX];
  logic [NAX-1:0]       link_q;
  logic [NAX-1:0]       az_ok_q;
  logic [NAX-1:0]       ax_hit;
  logic [NAX-1:0]       az_busy;
  logic [NAX-1:0]       eff_v;

  wire        wb_acc  = wb_cyc_i & wb_stb_i & ~ack_q;
  wire        wr_acc  = wb_acc & wb_we_i & (&wb_sel_i);
  wire        cmd_wr  = wr_acc & (wb_adr_i == motion_cmd_pkg::OFS_CMD);
  wire        arg_wr  = wr_acc & (wb_adr_i == motion_cmd_pkg::OFS_ARG);
  wire        err_rd  = wb_acc & ~wb_we_i & (wb_adr_i == motion_cmd_pkg::OFS_ERR);
  wire [3:0]  op      = wb_dat_i[3:0];
  wire [3:0]  ax      = wb_dat_i[7:4];
  wire        ax_ok   = |ax_hit;
  wire        is_stop = cmd_wr & (op == motion_cmd_pkg::OP_STOP_CHAR | op == motion_cmd_pkg::OP_STOP_ALL);
  wire        need_ax = op inside {motion_cmd_pkg::OP_OFS_SET, motion_cmd_pkg::OP_OFS_QRY,
                                   motion_cmd_pkg::OP_AZ_START, motion_cmd_pkg::OP_AZ_QRY,
                                   motion_cmd_pkg::OP_PARAM_OFS, motion_cmd_pkg::OP_TARGET,
                                   motion_cmd_pkg::OP_LINK};
  wire        lvl_op  = op == motion_cmd_pkg::OP_PARAM_OFS | op == motion_cmd_pkg::OP_LINK;
  wire [NAX-1:0] motion_v = move_busy | ref_busy | az_busy;
  wire        ready   = ~(|ref_busy) & ~(|az_busy);
  wire [31:0] status_w = {{(16-NAX){1'b0}}, link_q, {(8-NWG){1'b0}}, wave_run, 7'h00, ready};
  wire [31:0] rd_word =
    (wb_adr_i == motion_cmd_pkg::OFS_ARG)    ? {{(31-W){1'b0}}, arg_nan_q, arg_q} :
    (wb_adr_i == motion_cmd_pkg::OFS_RESP)   ? resp_q :
    (wb_adr_i == motion_cmd_pkg::OFS_ERR)    ? {24'h000000, err_q} :
    (wb_adr_i == motion_cmd_pkg::OFS_LEVEL)  ? {31'h00000000, level_q} :
    (wb_adr_i == motion_cmd_pkg::OFS_STATUS) ? status_w : 32'h00000000;

  // ------------------------------------------------
  // Error and response
  // ------------------------------------------------
  always_comb begin
    err_d = err_q;
    if (err_rd) begin
      err_d = motion_cmd_pkg::ERR_NONE;
    end
    if (is_stop) begin
      err_d = motion_cmd_pkg::ERR_STOPPED; // RQ4
    end else if (cmd_wr && need_ax && !ax_ok) begin
      err_d = motion_cmd_pkg::ERR_BAD_AXIS; // RQ24
    end else if (cmd_wr && op == motion_cmd_pkg::OP_TARGET && |(eff_v & ax_hit)) begin
      err_d = motion_cmd_pkg::ERR_ANALOG; // RQ15
    end else if (cmd_wr && lvl_op && !level_q) begin
      err_d = motion_cmd_pkg::ERR_LEVEL; // RQ11
    end
  end

  always_comb begin
    resp_d = resp_q;
    if (cmd_wr) begin
      unique case (op)
        motion_cmd_pkg::OP_MOTION: resp_d = {{(32-NAX){1'b0}}, motion_v}; // RQ1 RQ16 RQ25
        motion_cmd_pkg::OP_READY:  resp_d = {24'h000000, ready ? motion_cmd_pkg::READY_YES
                                                               : motion_cmd_pkg::READY_NO}; // RQ2
        motion_cmd_pkg::OP_WAVE:   resp_d = {{(32-NWG){1'b0}}, wave_run}; // RQ3
        motion_cmd_pkg::OP_IDENT:  resp_d = {motion_cmd_pkg::ID_NAME, motion_cmd_pkg::ID_SERIAL,
                                             motion_cmd_pkg::ID_FW, motion_cmd_pkg::ID_LF}; // RQ10
        default: begin
          for (int i = 0; i < NAX; i++) begin
            if (ax_hit[i] && op == motion_cmd_pkg::OP_OFS_QRY) begin
              resp_d = 32'($signed(ofs_q[i]));
            end
            if (ax_hit[i] && op == motion_cmd_pkg::OP_AZ_QRY) begin
              resp_d = {31'h00000000, az_ok_q[i]}; // RQ23
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q     <= 1'b0;
      dat_q     <= 32'h00000000;
      arg_q     <= '0;
      arg_nan_q <= 1'b0;
      level_q   <= 1'b0;
      err_q     <= motion_cmd_pkg::ERR_NONE;
      resp_q    <= 32'h00000000;
      stop_q    <= 1'b0;
    end else begin
      ack_q  <= wb_acc;
      dat_q  <= rd_word;
      err_q  <= err_d;
      resp_q <= resp_d;
      stop_q <= is_stop; // RQ5
      if (arg_wr) begin
        arg_q     <= wb_dat_i[W-1:0];
        arg_nan_q <= wb_dat_i[31];
      end
      if (cmd_wr && op == motion_cmd_pkg::OP_LEVEL) begin
        level_q <= arg_q[0];
      end
    end
  end

  assign wb_ack_o   = ack_q;
  assign wb_dat_o   = dat_q;
  assign stop_pulse = stop_q;
  assign analog_link = link_q;

  // ------------------------------------------------
  // Per-axis logic
  // ------------------------------------------------
  function automatic logic signed [W-1:0] clip(input logic signed [W:0] v,
                                              input logic signed [W-1:0] lo,
                                              input logic signed [W-1:0] hi);
    if (v < $signed({lo[W-1], lo})) begin
      return lo;
    end else if (v > $signed({hi[W-1], hi})) begin
      return hi;
    end
    return v[W-1:0];
  endfunction

  for (genvar i = 0; i < NAX; i++) begin : g_ax
    wire signed [W-1:0] pos_i  = position[i];
    wire signed [W-1:0] pmin   = pos_min[i];
    wire signed [W-1:0] pmax   = pos_max[i];
    wire signed [W-1:0] lo_raw = arg_nan_q ? $signed(az_low_par[i]) : arg_q; // RQ18
    wire signed [W-1:0] lo_pos = clip({lo_raw[W-1], lo_raw}, pmin, pmax); // RQ22
    wire signed [W:0]   sum    = $signed({analog_val[i][W-1], analog_val[i]}) + $signed({ofs_q[i][W-1], ofs_q[i]});
    wire signed [W-1:0] lim_lo = servo_on[i] ? $signed(cl_min[i]) : $signed(ol_min[i]);
    wire signed [W-1:0] lim_hi = servo_on[i] ? $signed(cl_max[i]) : $signed(ol_max[i]);
    wire signed [W-1:0] shaped = clip(sum, lim_lo, lim_hi); // RQ13 RQ14
    wire signed [W-1:0] zero_f = W'(servo_out[i] - force_val[i]);
    wire                hit    = cmd_wr & ax_hit[i];
    wire                settle = in_position[i] & (tmr_q[i] >= motion_cmd_pkg::AZ_SETTLE);
    wire                tmo    = tmr_q[i] == AZ_TMO;
    assign ax_hit[i]  = ax == 4'(i + 1);
    assign az_busy[i] = az_q[i] != motion_cmd_pkg::AZ_IDLE;
    assign eff_v[i]   = link_q[i] & ~az_busy[i]; // RQ12 RQ20
    assign target_value[i]  = tgt_q[i];
    assign control_value[i] = ctl_q[i];
    assign az_result[i]     = azr_q[i];
    assign analog_offset[i] = ofs_q[i];

    always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
        ofs_q[i]  <= '0;
        link_q[i] <= 1'b0;
      end else begin
        if (hit && (op == motion_cmd_pkg::OP_OFS_SET || (op == motion_cmd_pkg::OP_PARAM_OFS && level_q))) begin
          ofs_q[i] <= arg_q; // RQ11
        end
        if (is_stop) begin
          link_q[i] <= 1'b0; // RQ9
        end else if (hit && op == motion_cmd_pkg::OP_LINK && level_q) begin
          link_q[i] <= |arg_q;
        end
      end
    end

    always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
        az_q[i]    <= motion_cmd_pkg::AZ_IDLE;
        tgt_q[i]   <= '0;
        ctl_q[i]   <= '0;
        azr_q[i]   <= '0;
        low_q[i]   <= '0;
        tmr_q[i]   <= 32'h00000000;
        az_ok_q[i] <= 1'b0;
      end else if (is_stop) begin
        az_q[i] <= motion_cmd_pkg::AZ_IDLE; // RQ5 RQ16
        tmr_q[i] <= 32'h00000000;
        if (az_busy[i]) begin
          az_ok_q[i] <= 1'b0;
        end
        if (servo_on[i]) begin
          tgt_q[i] <= pos_ctrl[i] ? pos_i : '0; // RQ6 RQ7
        end else begin
          ctl_q[i] <= azr_q[i]; // RQ8
        end
      end else begin
        unique case (az_q[i])
          motion_cmd_pkg::AZ_IDLE: begin
            if (hit && op == motion_cmd_pkg::OP_AZ_START) begin
              az_q[i]  <= motion_cmd_pkg::AZ_HIGH; // RQ21
              tgt_q[i] <= az_high_par[i];
              low_q[i] <= lo_pos;
              tmr_q[i] <= 32'h00000000;
            end else if (eff_v[i] && servo_on[i]) begin
              tgt_q[i] <= shaped; // RQ13
            end else if (eff_v[i]) begin
              ctl_q[i] <= shaped; // RQ13
            end else if (hit && op == motion_cmd_pkg::OP_TARGET) begin
              tgt_q[i] <= arg_q;
            end
          end
          motion_cmd_pkg::AZ_HIGH: begin
            tmr_q[i] <= tmr_q[i] + 32'h00000001;
            if (settle) begin
              az_q[i]  <= motion_cmd_pkg::AZ_LOW; // RQ21
              tgt_q[i] <= low_q[i];
              tmr_q[i] <= 32'h00000000;
            end else if (tmo) begin
              az_q[i]    <= motion_cmd_pkg::AZ_IDLE;
              az_ok_q[i] <= 1'b0; // RQ23
            end
          end
          motion_cmd_pkg::AZ_LOW: begin
            tmr_q[i] <= tmr_q[i] + 32'h00000001;
            if (settle) begin
              az_q[i]    <= motion_cmd_pkg::AZ_IDLE;
              azr_q[i]   <= zero_f; // RQ17
              az_ok_q[i] <= 1'b1; // RQ23
            end else if (tmo) begin
              az_q[i]    <= motion_cmd_pkg::AZ_IDLE;
              az_ok_q[i] <= 1'b0;
            end
          end
          default: az_q[i] <= motion_cmd_pkg::AZ_IDLE;
        endcase
      end
    end

    chk_stop_position: assert property ( // RQ6
      is_stop && servo_on[i] && pos_ctrl[i] |=> tgt_q[i] == $past(pos_i))
      else $error("stopped position axis target is not present position");
    chk_stop_openloop: assert property ( // RQ8
      is_stop && !servo_on[i] |=> ctl_q[i] == azr_q[i])
      else $error("stopped open-loop axis control value wrong");
    chk_offset_clamp: assert property ( // RQ14
      !is_stop && !(hit && op == motion_cmd_pkg::OP_AZ_START) && eff_v[i] && servo_on[i] &&
      sum > $signed({lim_hi[W-1], lim_hi}) |=> tgt_q[i] == $past(lim_hi))
      else $error("analog target not clamped to upper limit");
  end

  // ------------------------------------------------
  // Checks
  // ------------------------------------------------
  chk_stop_error: assert property ( // RQ4
    is_stop |=> err_q == motion_cmd_pkg::ERR_STOPPED && stop_pulse && resp_q == $past(resp_q))
    else $error("stop did not set error 10 silently");
  chk_stop_sources: assert property ( // RQ5
    is_stop |=> az_busy == '0 && link_q == '0)
    else $error("stop left autozero or analog source active");
  chk_ready_code: assert property ( // RQ2
    cmd_wr && op == motion_cmd_pkg::OP_READY |=>
      resp_q[7:0] == ($past(ready) ? motion_cmd_pkg::READY_YES : motion_cmd_pkg::READY_NO))
    else $error("ready code mismatch");
  chk_motion_map: assert property ( // RQ1
    cmd_wr && op == motion_cmd_pkg::OP_MOTION |=> resp_q == {{(32-NAX){1'b0}}, $past(motion_v)})
    else $error("motion bitmap mismatch");
  chk_wave_map: assert property ( // RQ3
    cmd_wr && op == motion_cmd_pkg::OP_WAVE |=> resp_q == {{(32-NWG){1'b0}}, $past(wave_run)})
    else $error("wave bitmap mismatch");
  chk_target_reject: assert property ( // RQ15
    cmd_wr && op == motion_cmd_pkg::OP_TARGET && |(eff_v & ax_hit) |=> err_q == motion_cmd_pkg::ERR_ANALOG)
    else $error("target set on analog axis not rejected");
  chk_offset_level: assert property ( // RQ11
    cmd_wr && ax_ok && op == motion_cmd_pkg::OP_PARAM_OFS && !level_q |=> err_q == motion_cmd_pkg::ERR_LEVEL)
    else $error("generic offset write allowed at level 0");
  chk_ident_line: assert property ( // RQ10
    cmd_wr && op == motion_cmd_pkg::OP_IDENT |=> resp_q[7:0] == motion_cmd_pkg::ID_LF)
    else $error("identity answer lacks line feed");
  chk_bad_axis: assert property ( // RQ24
    cmd_wr && need_ax && !ax_ok && !is_stop |=> err_q == motion_cmd_pkg::ERR_BAD_AXIS && $stable(link_q))
    else $error("illegal axis not flagged");
endmodule

// File: verif/axis_plant.sv
/*
  Axis plant model: position follows the target plus bias after a settle delay.
  Assumes targets come from the command core on core_clk.
*/
module axis_plant #(
  parameter int NAX = 2,
  parameter int W   = 16
) (
  input  wire logic                  core_clk,
  input  wire logic [NAX-1:0][W-1:0] target_value,
  input  wire logic [W-1:0]          bias,
  input  wire logic [7:0]            dly,
  output logic      [NAX-1:0]        in_position,
  output logic      [NAX-1:0][W-1:0] position
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NAX-1:0][W-1:0] last_q = '0;
  logic [NAX-1:0][W-1:0] pos_q  = '0;
  logic [NAX-1:0][7:0]   cnt_q  = '0;
  logic [NAX-1:0]        inp_q  = '0;
  assign position    = pos_q;
  assign in_position = inp_q;
  // Slow or prompt settle set by dly
  always @(posedge core_clk) begin
    for (int i = 0; i < NAX; i++) begin
      last_q[i] <= target_value[i];
      if (target_value[i] !== last_q[i]) begin
        cnt_q[i] <= dly;
        inp_q[i] <= 1'b0;
      end else if (cnt_q[i] != 8'h00) begin
        cnt_q[i] <= cnt_q[i] - 8'h01;
      end else begin
        inp_q[i] <= 1'b1;
        pos_q[i] <= target_value[i] + bias;
      end
    end
  end
endmodule

// File: verif/test_motion_status_stop_offset_autozero.sv
/*
  Bench: Wishbone tasks, queued read checks, scenarios.
  Assumes the core package, core and axis plant are compiled first.
*/
module test_motion_status_stop_offset_autozero;
  timeunit 1ns;
  timeprecision 1ps;
  logic                core_clk = 1'b0;
  logic                resetn   = 1'b0;
  logic                wb_cyc_i = 1'b0;
  logic                wb_stb_i = 1'b0;
  logic                wb_we_i  = 1'b0;
  logic [7:0]          wb_adr_i = 8'h00;
  logic [31:0]         wb_dat_i = 32'h0000_0000;
  logic [3:0]          wb_sel_i = 4'hF;
  logic [31:0]         wb_dat_o;
  logic                wb_ack_o;
  logic                stop_pulse;
  logic [1:0]          servo_on = 2'b01;
  logic [1:0]          pos_ctrl = 2'b01;
  logic [1:0]          move_busy = 2'b00;
  logic [1:0]          ref_busy = 2'b00;
  logic [1:0]          in_position, analog_link, mb, rb;
  logic [2:0]          wave_run = 3'b000;
  logic [2:0]          wr;
  logic [1:0][15:0]    position, analog_val, force_val, servo_out, cl_min, cl_max, ol_min, ol_max;
  logic [1:0][15:0]    pos_min, pos_max, az_low_par, az_high_par;
  logic [1:0][15:0]    target_value, control_value, az_result, analog_offset;
  logic [15:0]         an, ofs, bias;
  logic [7:0]          dly;
  logic [31:0]         exp_q[$];
  int                  n_fail = 0;
  int                  total_checks = 0;
  int                  cyc_n = 0;
  motion_cmd_core #(.NAX(2), .NWG(3), .W(16), .AZ_TMO(200)) dut (
    .core_clk(core_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .servo_on(servo_on), .pos_ctrl(pos_ctrl), .move_busy(move_busy), .ref_busy(ref_busy),
    .in_position(in_position), .wave_run(wave_run), .position(position), .analog_val(analog_val),
    .force_val(force_val), .servo_out(servo_out), .cl_min(cl_min), .cl_max(cl_max), .ol_min(ol_min),
    .ol_max(ol_max), .pos_min(pos_min), .pos_max(pos_max), .az_low_par(az_low_par), .az_high_par(az_high_par),
    .target_value(target_value), .control_value(control_value), .az_result(az_result),
    .analog_offset(analog_offset), .analog_link(analog_link), .stop_pulse(stop_pulse));
  axis_plant #(.NAX(2), .W(16)) plant (.core_clk(core_clk), .target_value(target_value), .bias(bias),
    .dly(dly), .in_position(in_position), .position(position));
  // ------------------------------------------------
  // Clock, timeout, read checker
  // ------------------------------------------------
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 30000) begin
      n_fail++;
      summarize();
    end
  end
  always @(posedge core_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) check("rdata", wb_dat_o, exp_q.pop_front());
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic we);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic cmd(input logic [3:0] op, input logic [3:0] ax, input logic [31:0] arg);
    wb(motion_cmd_pkg::OFS_ARG, arg, 1'b1);
    wb(motion_cmd_pkg::OFS_CMD, {24'h0, ax, op}, 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(a, 32'h0, 1'b0);
  endtask
  task automatic qry(input logic [3:0] op, ax, input logic [31:0] e);
    cmd(op, ax, 32'h0);
    rd(motion_cmd_pkg::OFS_RESP, e);
  endtask
  task automatic erc(input logic [7:0] e);
    rd(motion_cmd_pkg::OFS_ERR, {24'h0, e});
  endtask
  function automatic logic [15:0] clampv(input logic signed [15:0] a, b, lo, hi);
    logic signed [16:0] s;
    s = a + b;
    if (s < lo) return lo;
    if (s > hi) return hi;
    return s[15:0];
  endfunction
  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  initial begin
    void'($urandom(92348));
    an = 16'h0040 + 16'($urandom % 128);
    bias = 16'h0001 + 16'($urandom % 32);
    dly = 8'h02 + 8'($urandom % 24);
    analog_val = {an, an};
    cl_min = {2{16'hFC00}};
    cl_max = {2{16'h0100 + 16'($urandom % 64)}};
    ol_min = {2{16'hFF80}};
    ol_max = {2{16'h0080 + 16'($urandom % 32)}};
    pos_min = {2{16'hFF00}};
    pos_max = {2{16'h0100}};
    az_low_par = {2{16'hFE00 - 16'($urandom % 256)}};
    az_high_par = {2{16'h0040 + 16'($urandom % 32)}};
    force_val = {2{16'h0001 + 16'($urandom % 8)}};
    servo_out = {2{16'h0040 + 16'($urandom % 64)}};
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    check("tgt_rst", 32'(target_value), 32'h0);
    rd(motion_cmd_pkg::OFS_LEVEL, 32'h0);
    for (int i = 0; i < 6; i++) begin
      mb = 2'($urandom);
      rb = 2'(i % 2);
      wr = 3'($urandom);
      move_busy <= mb | rb;
      ref_busy <= rb;
      wave_run <= wr;
      qry(motion_cmd_pkg::OP_MOTION, 4'h0, {30'h0, mb | rb});
      qry(motion_cmd_pkg::OP_READY, 4'h0,
          {24'h0, rb[0] ? motion_cmd_pkg::READY_NO : motion_cmd_pkg::READY_YES});
      qry(motion_cmd_pkg::OP_WAVE, 4'h0, {29'h0, wr});
    end
    move_busy <= 2'b00;
    ref_busy <= 2'b00;
    qry(motion_cmd_pkg::OP_IDENT, 4'h0, {motion_cmd_pkg::ID_NAME, motion_cmd_pkg::ID_SERIAL, motion_cmd_pkg::ID_FW,
      motion_cmd_pkg::ID_LF});
    ofs = 16'h0020;
    cmd(motion_cmd_pkg::OP_OFS_SET, 4'h1, {16'h0, ofs});
    cmd(motion_cmd_pkg::OP_PARAM_OFS, 4'h1, 32'h0000_0100);
    erc(motion_cmd_pkg::ERR_LEVEL);
    for (int a = 0; a < 4; a += 3) begin
      cmd(motion_cmd_pkg::OP_OFS_SET, 4'(a), 32'h0000_0100);
      erc(motion_cmd_pkg::ERR_BAD_AXIS);
    end
    wb_sel_i <= 4'h3;
    cmd(motion_cmd_pkg::OP_OFS_SET, 4'h1, 32'h0000_0100);
    wb_sel_i <= 4'hF;
    check("ofs_kept", 32'(analog_offset), {16'h0, ofs});
    check("tgt_unlinked", 32'(target_value[0]), 32'h0);
    cmd(motion_cmd_pkg::OP_LEVEL, 4'h0, 32'h1);
    rd(motion_cmd_pkg::OFS_LEVEL, 32'h1);
    cmd(motion_cmd_pkg::OP_OFS_SET, 4'h2, 32'h0000_0400);
    cmd(motion_cmd_pkg::OP_LINK, 4'h1, 32'h1);
    cmd(motion_cmd_pkg::OP_LINK, 4'h2, 32'h1);
    repeat (4) @(posedge core_clk);
    check("tgt_analog", 32'(target_value[0]), 32'(clampv(an, ofs, cl_min[0], cl_max[0])));
    check("ctl_clamp", 32'(control_value[1]), 32'(ol_max[1]));
    cmd(motion_cmd_pkg::OP_TARGET, 4'h1, 32'h0000_0011);
    erc(motion_cmd_pkg::ERR_ANALOG);
    ofs = 16'h0400;
    cmd(motion_cmd_pkg::OP_OFS_SET, 4'h1, {16'h0, ofs});
    repeat (4) @(posedge core_clk);
    check("tgt_clamp", 32'(target_value[0]), 32'(cl_max[0]));
    erc(motion_cmd_pkg::ERR_NONE);
    for (int k = 0; k < 2; k++) begin
      pos_ctrl <= {1'b0, k == 0};
      cmd(motion_cmd_pkg::OP_LINK, 4'h1, 32'h1);
      cmd(motion_cmd_pkg::OP_LINK, 4'h2, 32'h1);
      repeat (64) @(posedge core_clk);
      cmd(k ? motion_cmd_pkg::OP_STOP_ALL : motion_cmd_pkg::OP_STOP_CHAR, 4'h0, 32'h0);
      check("stop_pulse", 32'(stop_pulse), 32'h1);
      check("stop_tgt", 32'(target_value[0]), k ? 32'h0 : 32'(16'(cl_max[0] + bias)));
      check("stop_ctl", 32'(control_value[1]), 32'h0);
      check("stop_link", 32'(analog_link), 32'h0);
      erc(motion_cmd_pkg::ERR_STOPPED);
    end
    pos_ctrl <= 2'b01;
    ref_busy <= 2'b01;
    qry(motion_cmd_pkg::OP_READY, 4'h0, {24'h0, motion_cmd_pkg::READY_NO});
    ref_busy <= 2'b00;
    cmd(motion_cmd_pkg::OP_LINK, 4'h1, 32'h1);
    cmd(motion_cmd_pkg::OP_AZ_START, 4'h1, 32'h8000_0000);
    qry(motion_cmd_pkg::OP_MOTION, 4'h0, 32'h1);
    for (int i = 0; i < 400 && target_value[0] !== az_high_par[0]; i++) @(posedge core_clk);
    check("az_high", 32'(target_value[0]), 32'(az_high_par[0]));
    for (int i = 0; i < 400 && target_value[0] !== pos_min[0]; i++) @(posedge core_clk);
    check("az_low", 32'(target_value[0]), 32'(pos_min[0]));
    for (int i = 0; i < 400 && az_result[0] !== 16'(servo_out[0] - force_val[0]); i++) @(posedge core_clk);
    check("az_res", 32'(az_result[0]), 32'(16'(servo_out[0] - force_val[0])));
    qry(motion_cmd_pkg::OP_AZ_QRY, 4'h1, 32'h1);
    qry(motion_cmd_pkg::OP_MOTION, 4'h0, 32'h0);
    check("az_restore", 32'(target_value[0]), 32'(cl_max[0]));
    servo_on <= 2'b00;
    cmd(motion_cmd_pkg::OP_AZ_START, 4'h1, 32'h0000_0010);
    cmd(motion_cmd_pkg::OP_STOP_ALL, 4'h0, 32'h0);
    check("stop_ctl_az", 32'(control_value[0]), 32'(16'(servo_out[0] - force_val[0])));
    erc(motion_cmd_pkg::ERR_STOPPED);
    qry(motion_cmd_pkg::OP_AZ_QRY, 4'h1, 32'h0);
    qry(motion_cmd_pkg::OP_MOTION, 4'h0, 32'h0);
    repeat (4) @(posedge core_clk);
    summarize();
  end
endmodule
